/* File: include/pct_pkg.sv */
// shared constants and types for the target user port
package pct_pkg;
    // ==================================================
    // widths
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam int REGION_N = 8;
    localparam int CMD_N = 16;
    localparam int CSV_W = 40;
    localparam int SUB_N = 4;
    // ==================================================
    // bus commands
    localparam logic [3:0] CMD_IO_READ = 4'h2;
    localparam logic [3:0] CMD_IO_WRITE = 4'h3;
    localparam logic [15:0] CMD_ACCEPT = 16'h00cc;
    // ==================================================
    // answer codes of the request port
    localparam logic [1:0] RSP_DONE = 2'h0;
    localparam logic [1:0] RSP_RETRY = 2'h1;
    localparam logic [1:0] RSP_ABORT = 2'h2;
    localparam logic [1:0] RSP_NOCLAIM = 2'h3;
    // ==================================================
    // transfer status bits of the status vector
    localparam int CSV_DATA = 32;
    localparam int CSV_BACK = 33;
    localparam int CSV_RETRY = 34;
    localparam int CSV_ABORT = 35;
    localparam int CSV_FIRST = 36;
    localparam int CSV_WRITE = 37;
    localparam int CSV_LAST = 38;
    localparam int CSV_DISC = 39;
    // ==================================================
    // software registers
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_COUNT = 8'h08;
    localparam logic [7:0] OFS_DATA0 = 8'h10;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] CTRL_MASK = 32'h0000_00f7;
    localparam int CTRL_BURST = 0;
    localparam int CTRL_RETRY = 1;
    localparam int CTRL_ABORT = 2;
    localparam int CTRL_WAIT_LSB = 4;
    localparam logic [3:0] WAIT_LEAD = 4'h3;
    // ==================================================
    // core target states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_BUSY = 3'b010,
        ST_DATA = 3'b011,
        ST_BACK = 3'b100
    } pct_state_type;
endpackage

/* File: include/pct_if.sv */
// carrier between the core end and the application end
`timescale 1ns/1ps
`default_nettype none
interface pct_if;
    import pct_pkg::*;
    logic [REGION_N-1:0] region_claim;
    logic [ADDR_W-1:0] bus_addr;
    logic location_strobe;
    logic target_write_dir;
    logic [3:0] delayed_byte_lanes;
    logic [CMD_N-1:0] cmd_onehot;
    logic phase_done_strobe;
    logic next_source_word;
    logic [CSV_W-1:0] core_status_vector;
    logic st_idle;
    logic st_busy;
    logic st_data;
    logic target_waiting_end;
    logic target_ready_ctl;
    logic stop_ctl;
    logic abort_ctl;
    logic [DATA_W-1:0] core_ad_out;
    logic core_ad_oe;
    logic [DATA_W-1:0] app_ad_out;
    logic app_ad_oe;
    logic [DATA_W-1:0] shared_addr_data_bus;
    // =============================================
    // bus level; undriven reads as zero
    assign shared_addr_data_bus = app_ad_oe ? app_ad_out : (core_ad_oe ? core_ad_out : '0);
    modport core_mp (
        output region_claim, bus_addr, location_strobe, target_write_dir,
        output delayed_byte_lanes, cmd_onehot, phase_done_strobe, next_source_word,
        output core_status_vector, st_idle, st_busy, st_data, target_waiting_end,
        output core_ad_out, core_ad_oe,
        input target_ready_ctl, stop_ctl, abort_ctl, shared_addr_data_bus
    );
    modport app_mp (
        input region_claim, bus_addr, location_strobe, target_write_dir,
        input delayed_byte_lanes, cmd_onehot, phase_done_strobe, next_source_word,
        input core_status_vector, st_idle, st_busy, st_data, target_waiting_end,
        input shared_addr_data_bus,
        output target_ready_ctl, stop_ctl, abort_ctl, app_ad_out, app_ad_oe
    );
endinterface
`default_nettype wire

/* File: hdl/pct_core.sv */
// core end: runs bus transactions and drives the user-side target port
`timescale 1ns/1ps
`default_nettype none
module pct_core
    import pct_pkg::*;
#(
    parameter logic [REGION_N-1:0] BURST_REGIONS = 8'h01
) (
    input wire logic clk_i,
    input wire logic rst_i,
    pct_if.core_mp bus,
    input wire logic req_valid_i,
    output logic req_ready_o,
    input wire logic [ADDR_W-1:0] req_addr_i,
    input wire logic [3:0] req_cmd_i,
    input wire logic [3:0] req_be_i,
    input wire logic [DATA_W-1:0] req_wdata_i,
    input wire logic [3:0] req_words_i,
    input wire logic req_hit_i,
    input wire logic [2:0] req_region_i,
    output logic rsp_valid_o,
    output logic [1:0] rsp_status_o,
    output logic [DATA_W-1:0] rsp_rdata_o,
    output logic [3:0] rsp_count_o,
    output logic target_ready_pin_n_o,
    output logic device_select_pin_n_o
);
    // ==================================================
    // state and request copy
    pct_state_type state, next_state;
    logic [ADDR_W-1:0] addr_q;
    logic [DATA_W-1:0] wdata_q;
    logic [3:0] cmd_q, be_q, words_q, count;
    logic hit_q, rdy_q, stop_q, abort_q;
    logic [2:0] region_q;
    logic retry_q, abort_seen, disc_q;
    logic [CSV_W-1:0] csv;
    // ==================================================
    // decode
    wire logic take = req_valid_i & (state == ST_IDLE);
    wire logic in_addr = (state == ST_ADDR);
    wire logic in_data = (state == ST_DATA);
    wire logic writing = cmd_q[0];
    wire logic is_io = (cmd_q == CMD_IO_READ) | (cmd_q == CMD_IO_WRITE);
    wire logic burst_ok = BURST_REGIONS[region_q] & ~is_io;
    wire logic [3:0] count_inc = 4'(count + 4'h1);
    // zero words acts as one word
    wire logic last_word = ~burst_ok | (count_inc >= words_q);
    wire logic phase_ok = in_data & rdy_q & ~abort_q;
    wire logic finish_phase = phase_ok & (last_word | stop_q);
    wire logic nodata_stop = in_data & ~abort_q & ~rdy_q & stop_q;
    wire logic abort_now = in_data & abort_q;
    wire logic end_txn = finish_phase | nodata_stop | abort_now;
    wire logic [3:0] cbe_pins = in_addr ? cmd_q : be_q;

    assign req_ready_o = (state == ST_IDLE);
    assign bus.location_strobe = in_addr;
    assign bus.st_idle = (state == ST_IDLE);
    assign bus.st_busy = in_addr | (state == ST_BUSY);
    assign bus.st_data = in_data;
    assign bus.target_waiting_end = (state == ST_BACK);
    assign bus.phase_done_strobe = phase_ok;
    // only while a read burst goes on past this phase
    assign bus.next_source_word = phase_ok & ~writing & burst_ok & ~last_word & ~stop_q;
    assign bus.core_ad_out = in_addr ? addr_q : DATA_W'(wdata_q + {28'h0, count});
    assign bus.core_ad_oe = in_addr | (in_data & writing);
    assign target_ready_pin_n_o = ~phase_ok;
    assign device_select_pin_n_o = ~(in_data | (state == ST_BACK));
    assign bus.core_status_vector = csv;

    always_comb begin
        csv = '0;
        csv[3:0] = cmd_q;
        csv[CSV_DATA] = in_data;
        csv[CSV_BACK] = (state == ST_BACK);
        csv[CSV_RETRY] = retry_q;
        csv[CSV_ABORT] = abort_seen;
        csv[CSV_FIRST] = in_data & (count == 4'h0);
        csv[CSV_WRITE] = writing;
        csv[CSV_LAST] = in_data & last_word;
        csv[CSV_DISC] = disc_q;
    end

    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (take) begin
                    next_state = ST_ADDR;
                end
            end
            ST_ADDR: next_state = ST_BUSY;
            ST_BUSY: next_state = hit_q ? ST_DATA : ST_IDLE;
            ST_DATA: begin
                if (abort_now) begin
                    next_state = ST_IDLE;
                end else if (finish_phase | nodata_stop) begin
                    next_state = stop_q ? ST_BACK : ST_IDLE;
                end
            end
            ST_BACK: next_state = ST_IDLE;
            default: next_state = ST_IDLE;
        endcase
    end

    // ==================================================
    // registers; async reset shared with the application
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state <= ST_IDLE;
            {addr_q, wdata_q, cmd_q, be_q, words_q, hit_q, region_q} <= '0;
            {rdy_q, stop_q, abort_q} <= '0;
        end else begin
            state <= next_state;
            // controls act one clock after the application sets them
            rdy_q <= bus.target_ready_ctl;
            stop_q <= bus.stop_ctl;
            abort_q <= bus.abort_ctl;
            if (take) begin
                {addr_q, wdata_q, cmd_q, be_q} <= {req_addr_i, req_wdata_i, req_cmd_i, req_be_i};
                {words_q, hit_q, region_q} <= {req_words_i, req_hit_i, req_region_i};
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            bus.region_claim <= '0;
            bus.bus_addr <= '0;
            bus.target_write_dir <= 1'b0;
            bus.delayed_byte_lanes <= 4'hf;
            bus.cmd_onehot <= '0;
        end else begin
            bus.delayed_byte_lanes <= cbe_pins;
            bus.region_claim <= (in_addr & hit_q) ? REGION_N'(8'h01 << region_q) : '0;
            if (in_addr) begin
                bus.bus_addr <= addr_q;
                bus.cmd_onehot <= CMD_N'(16'h0001 << cmd_q);
                bus.target_write_dir <= cmd_q[0];
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            count <= 4'h0;
            {retry_q, abort_seen, disc_q} <= '0;
            rsp_valid_o <= 1'b0;
            rsp_status_o <= RSP_DONE;
            rsp_rdata_o <= '0;
            rsp_count_o <= 4'h0;
        end else begin
            rsp_valid_o <= end_txn | ((state == ST_BUSY) & ~hit_q);
            if (take) begin
                count <= 4'h0;
                {retry_q, abort_seen, disc_q} <= '0;
            end else if (phase_ok) begin
                count <= count_inc;
            end
            if (phase_ok & ~writing) begin
                rsp_rdata_o <= bus.shared_addr_data_bus;
            end
            if (nodata_stop & (count == 4'h0)) begin
                retry_q <= 1'b1;
            end
            if (abort_now) begin
                abort_seen <= 1'b1;
            end
            if (stop_q & (finish_phase | nodata_stop)) begin
                disc_q <= 1'b1;
            end
            if (end_txn | ((state == ST_BUSY) & ~hit_q)) begin
                rsp_count_o <= phase_ok ? count_inc : count;
                if (abort_now) begin
                    rsp_status_o <= RSP_ABORT;
                end else if (nodata_stop & (count == 4'h0)) begin
                    rsp_status_o <= RSP_RETRY;
                end else if (state == ST_BUSY) begin
                    rsp_status_o <= RSP_NOCLAIM;
                end else begin
                    rsp_status_o <= RSP_DONE;
                end
            end
        end
    end
endmodule
`default_nettype wire

/* File: hdl/pct_app.sv */
// application end: target registers, select logic, controls, software port
`timescale 1ns/1ps
`default_nettype none
module pct_app
    import pct_pkg::*;
#(
    parameter int SERVE_REGION = 0
) (
    input wire logic clk_i,
    input wire logic rst_i,
    pct_if.app_mp bus,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o
);
    // ==================================================
    // storage
    logic [DATA_W-1:0] regs [SUB_N];
    logic [SUB_N-1:0] rd_sel, wr_sel, sub_hit;
    logic [31:0] ctrl;
    logic [15:0] phase_cnt;
    logic [REGION_N-1:0] last_claim;
    logic [3:0] timer, next_timer;
    logic ready_q, stop_q, abort_q;
    logic [DATA_W-1:0] rd_mux;
    logic [31:0] wb_rdat;
    logic [31:0] status;

    // ==================================================
    // decode
    wire logic claim = bus.region_claim[SERVE_REGION];
    wire logic cmd_ok = |(bus.cmd_onehot & CMD_ACCEPT);
    wire logic [1:0] sub_idx = bus.bus_addr[3:2];
    wire logic wr_advance = bus.phase_done_strobe & (|wr_sel);
    wire logic rd_advance = bus.next_source_word & (|rd_sel);
    wire logic wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire logic wb_wr = wb_req & wb_we_i;
    wire logic hit_ctrl = (wb_adr_i == OFS_CTRL);
    wire logic hit_status = (wb_adr_i == OFS_STATUS);
    wire logic hit_count = (wb_adr_i == OFS_COUNT);
    wire logic hit_data = (wb_adr_i[7:4] == OFS_DATA0[7:4]);
    wire logic [1:0] wb_idx = wb_adr_i[3:2];
    wire logic waiting = (next_timer > WAIT_LEAD);

    // ==================================================
    // select flops, one pair per sub-region
    // four sub-regions cover the low address bits, so nothing is left unmapped
    for (genvar k = 0; k < SUB_N; k++) begin : g_sel
        localparam int PREV = (k + SUB_N - 1) % SUB_N;
        assign sub_hit[k] = cmd_ok & (sub_idx == 2'(k));
        always_ff @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
                rd_sel[k] <= 1'b0;
                wr_sel[k] <= 1'b0;
            end else if (claim) begin
                rd_sel[k] <= ~bus.target_write_dir & sub_hit[k];
                wr_sel[k] <= bus.target_write_dir & sub_hit[k];
            end else if (~bus.st_data) begin
                rd_sel[k] <= 1'b0;
                wr_sel[k] <= 1'b0;
            end else if (rd_advance) begin
                rd_sel[k] <= rd_sel[PREV];
            end else if (wr_advance) begin
                wr_sel[k] <= wr_sel[PREV];
            end
        end
    end

    // ==================================================
    // read path: whole word, never byte gated
    always_comb begin
        rd_mux = '0;
        for (int k = 0; k < SUB_N; k++) begin
            if (rd_sel[k]) begin
                rd_mux = rd_mux | regs[k];
            end
        end
    end

    assign bus.app_ad_out = rd_mux;
    assign bus.app_ad_oe = (|rd_sel) & bus.st_data & ~rst_i;

    // ==================================================
    // target registers; a bus load beats a software write in the same clock
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            for (int k = 0; k < SUB_N; k++) begin
                regs[k] <= '0;
            end
        end else begin
            for (int k = 0; k < SUB_N; k++) begin
                for (int b = 0; b < 4; b++) begin
                    if (wr_sel[k] & bus.phase_done_strobe & ~bus.delayed_byte_lanes[b]) begin
                        regs[k][8*b +: 8] <= bus.shared_addr_data_bus[8*b +: 8];
                    end else if (wb_wr & hit_data & (wb_idx == 2'(k)) & wb_sel_i[b]) begin
                        regs[k][8*b +: 8] <= wb_dat_i[8*b +: 8];
                    end
                end
            end
        end
    end

    // ==================================================
    // data phase controls, all from flops
    always_comb begin
        if (bus.location_strobe) begin
            next_timer = ctrl[CTRL_WAIT_LSB +: 4];
        end else if (timer != 4'h0) begin
            next_timer = timer - 4'h1;
        end else begin
            next_timer = timer;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            timer <= 4'h0;
            abort_q <= 1'b1;
            ready_q <= 1'b0;
            stop_q <= 1'b0;
        end else begin
            // the timer only runs from the address strobe, so waits precede the first phase
            timer <= next_timer;
            ready_q <= ~waiting & ~ctrl[CTRL_RETRY];
            stop_q <= ~waiting & (ctrl[CTRL_RETRY] | ~ctrl[CTRL_BURST]);
            abort_q <= ctrl[CTRL_ABORT];
        end
    end

    assign bus.target_ready_ctl = ready_q;
    assign bus.stop_ctl = stop_q;
    assign bus.abort_ctl = abort_q;

    // ==================================================
    // software view
    always_comb begin
        status = '0;
        status[3:0] = {bus.target_waiting_end, bus.st_data, bus.st_busy, bus.st_idle};
        status[15:8] = last_claim;
        status[18:16] = {abort_q, stop_q, ready_q};
        status[23:20] = {|wr_sel, |rd_sel, bus.core_status_vector[CSV_RETRY],
                         bus.core_status_vector[CSV_ABORT]};
    end

    assign wb_rdat = hit_ctrl ? ctrl :
                     hit_status ? status :
                     hit_count ? {16'h0000, phase_cnt} :
                     hit_data ? regs[wb_idx] : 32'h0000_0000;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl <= CTRL_RESET;
            phase_cnt <= 16'h0000;
            last_claim <= '0;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            // unmapped offsets still answer, reading zero
            wb_ack_o <= wb_req;
            if (wb_req & ~wb_we_i) begin
                wb_dat_o <= wb_rdat;
            end
            for (int b = 0; b < 4; b++) begin
                if (wb_wr & hit_ctrl & wb_sel_i[b]) begin
                    ctrl[8*b +: 8] <= wb_dat_i[8*b +: 8] & CTRL_MASK[8*b +: 8];
                end
            end
            if (|bus.region_claim) begin
                last_claim <= bus.region_claim;
            end
            // a phase in the clearing clock still counts
            if (bus.phase_done_strobe & ((|rd_sel) | (|wr_sel))) begin
                phase_cnt <= (wb_wr & hit_count) ? 16'h0001 : 16'(phase_cnt + 16'h0001);
            end else if (wb_wr & hit_count) begin
                phase_cnt <= 16'h0000;
            end
        end
    end
endmodule
`default_nettype wire

/* File: tb/pct_properties.sv */
// concurrent checks on the signals between the core end and the application end
`timescale 1ns/1ps
`default_nettype none
module pct_properties
    import pct_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [REGION_N-1:0] region_claim,
    input wire logic [ADDR_W-1:0] bus_addr,
    input wire logic location_strobe,
    input wire logic target_write_dir,
    input wire logic [CMD_N-1:0] cmd_onehot,
    input wire logic phase_done_strobe,
    input wire logic next_source_word,
    input wire logic [CSV_W-1:0] core_status_vector,
    input wire logic st_idle,
    input wire logic st_busy,
    input wire logic st_data,
    input wire logic target_waiting_end,
    input wire logic app_ad_oe
);
    // ==================================================
    // one clock domain, reset masks everything
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_claim;
        region_claim != '0 |-> $onehot(region_claim) ##1 region_claim == '0;
    endproperty
    a_claim: assert property (p_claim) else $error("claim not a one-clock one-hot pulse");
    property p_strobe;
        location_strobe |-> st_busy ##1 !location_strobe;
    endproperty
    a_strobe: assert property (p_strobe) else $error("address strobe too long");
    // address and direction must not move once the data state is reached
    property p_held;
        (st_data || target_waiting_end) |-> $stable(bus_addr) && $stable(target_write_dir);
    endproperty
    a_held: assert property (p_held) else $error("address or direction moved");
    property p_cmd;
        region_claim != '0 |-> cmd_onehot == (16'h0001 << core_status_vector[3:0]) ##1 st_data;
    endproperty
    a_cmd: assert property (p_cmd) else $error("decoded command wrong at claim");
    property p_phase;
        phase_done_strobe |-> st_data;
    endproperty
    a_phase: assert property (p_phase) else $error("phase strobe outside data state");
    property p_src;
        next_source_word |-> phase_done_strobe && !target_write_dir;
    endproperty
    a_src: assert property (p_src) else $error("source advance outside read phase");
    property p_state;
        $onehot({st_idle, st_busy, st_data, target_waiting_end});
    endproperty
    a_state: assert property (p_state) else $error("state indications not one-hot");
    property p_csv;
        core_status_vector[33:32] == {target_waiting_end, st_data};
    endproperty
    a_csv: assert property (p_csv) else $error("status vector transfer bits wrong");
    property p_oe;
        app_ad_oe |-> st_data && !target_write_dir;
    endproperty
    a_oe: assert property (p_oe) else $error("application drives bus outside read data");
endmodule
`default_nettype wire

/* File: tb/pci_target_user_port_tb.sv */
// self-checking bench: core and application ends joined by the carrier
`timescale 1ns/1ps
`default_nettype none
module pci_target_user_port_tb;
    import pct_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic rv = 1'b0, rh = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [31:0] ra = '0, rd = '0, wd = '0, q;
    logic [3:0] rc = '0, rb = '0, rw = '0, sel = 4'hf;
    logic [2:0] rr = '0;
    logic [7:0] adr = '0;
    logic rdy, rsp_v, ack;
    logic [1:0] rsp_s;
    logic [31:0] rsp_d, wb_q;
    logic [3:0] rsp_n;
    logic trdy_n, devsel_n;
    int n_fail = 0, num_checks = 0;
    int n_trdy = 0, n_sel = 0;
    logic [31:0] mode_ctrl [3] = '{32'h0000_0002, 32'h0000_0004, 32'h0000_0070};
    logic [1:0] mode_rsp [3] = '{RSP_RETRY, RSP_ABORT, RSP_DONE};
    pct_if bus_if ();
    pct_core i_pct_core (.clk_i(clk_i), .rst_i(rst_i), .bus(bus_if), .req_valid_i(rv),
        .req_ready_o(rdy), .req_addr_i(ra), .req_cmd_i(rc), .req_be_i(rb), .req_wdata_i(rd),
        .req_words_i(rw), .req_hit_i(rh), .req_region_i(rr), .rsp_valid_o(rsp_v),
        .rsp_status_o(rsp_s), .rsp_rdata_o(rsp_d), .rsp_count_o(rsp_n),
        .target_ready_pin_n_o(trdy_n), .device_select_pin_n_o(devsel_n));
    pct_app i_pct_app (.clk_i(clk_i), .rst_i(rst_i), .bus(bus_if), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd),
        .wb_dat_o(wb_q), .wb_ack_o(ack));
    pct_properties i_pct_properties (.clk_i(clk_i), .rst_i(rst_i),
        .region_claim(bus_if.region_claim), .bus_addr(bus_if.bus_addr),
        .location_strobe(bus_if.location_strobe), .target_write_dir(bus_if.target_write_dir),
        .cmd_onehot(bus_if.cmd_onehot), .phase_done_strobe(bus_if.phase_done_strobe),
        .next_source_word(bus_if.next_source_word),
        .core_status_vector(bus_if.core_status_vector), .st_idle(bus_if.st_idle),
        .st_busy(bus_if.st_busy), .st_data(bus_if.st_data),
        .target_waiting_end(bus_if.target_waiting_end), .app_ad_oe(bus_if.app_ad_oe));
    // ==================================================
    // clock and watchdog
    initial begin
        forever #20 clk_i = ~clk_i;
    end
    // pin monitor: cycles with target ready low and with device select low
    always @(posedge clk_i) begin
        if (!rst_i && trdy_n === 1'b0) begin
            n_trdy <= n_trdy + 1;
        end
        if (!rst_i && devsel_n === 1'b0) begin
            n_sel <= n_sel + 1;
        end
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        n_fail++;
        complete_run();
    end
    // ==================================================
    // tasks
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    // one classic cycle; request held until ack is sampled high
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wd <= d;
        do @(posedge clk_i); while (ack !== 1'b1);
        q = wb_q;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic req(input logic [31:0] a, input logic [3:0] c, input logic [3:0] b,
        input logic [31:0] d, input logic [3:0] w, input logic h, input logic [2:0] r);
        @(posedge clk_i);
        rv <= 1'b1;
        ra <= a;
        rc <= c;
        rb <= b;
        rd <= d;
        rw <= w;
        rh <= h;
        rr <= r;
        do @(posedge clk_i); while (rdy !== 1'b1);
        rv <= 1'b0;
        do @(posedge clk_i); while (rsp_v !== 1'b1);
    endtask
    task automatic complete_run();
        if (n_fail == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // ==================================================
    // scenarios
    initial begin
        repeat (4) @(posedge clk_i);
        chk("abort_in_reset", bus_if.abort_ctl, 32'h0000_0001);
        rst_i <= 1'b0;
        @(posedge clk_i);
        #1 chk("ctl_after_reset", {bus_if.abort_ctl, bus_if.target_ready_ctl, bus_if.stop_ctl}, 3);
        wb(1'b0, OFS_CTRL, '0);
        chk("ctrl_reset", q, CTRL_RESET);
        wb(1'b1, OFS_DATA0 + 8'h04, '0);
        req(32'h0, CMD_IO_WRITE, 4'h0, 32'h1234_5678, 4'h1, 1'b1, 3'h0);
        chk("single_wr", {rsp_s, rsp_n}, {RSP_DONE, 4'h1});
        req(32'h4, CMD_IO_WRITE, 4'hc, 32'haaaa_bbbb, 4'h1, 1'b1, 3'h0);
        req(32'h4, CMD_IO_READ, 4'hf, '0, 4'h1, 1'b1, 3'h0);
        chk("byte_load", rsp_d, 32'h0000_bbbb);
        req(32'h0, CMD_IO_READ, 4'h0, '0, 4'h1, 1'b1, 3'h0);
        chk("single_rd", rsp_d, 32'h1234_5678);
        wb(1'b1, OFS_CTRL, 32'h0000_0001);
        wb(1'b1, OFS_COUNT, '0);
        req(32'h0, 4'h7, 4'h0, 32'h5000_0000, 4'h4, 1'b1, 3'h0);
        chk("burst_wr", {rsp_s, rsp_n}, {RSP_DONE, 4'h4});
        for (int i = 0; i < 4; i++) begin
            wb(1'b0, OFS_DATA0 + 8'(4 * i), '0);
            chk("burst_word", q, 32'h5000_0000 + i);
        end
        req(32'h0, 4'h6, 4'h0, '0, 4'h4, 1'b1, 3'h0);
        chk("burst_rd", rsp_d, 32'h5000_0003);
        chk("burst_rd_count", rsp_n, 4'h4);
        wb(1'b0, OFS_COUNT, '0);
        chk("phase_count", q, 32'h0000_0008);
        req(32'h0, CMD_IO_WRITE, 4'h0, 32'h0000_0077, 4'h4, 1'b1, 3'h0);
        chk("io_no_burst", rsp_n, 4'h1);
        for (int i = 0; i < 3; i++) begin
            wb(1'b1, OFS_CTRL, mode_ctrl[i]);
            req(32'h8, CMD_IO_WRITE, 4'h0, 32'h0000_0099, 4'h1, 1'b1, 3'h0);
            chk("ctl_mode", rsp_s, mode_rsp[i]);
        end
        req(32'h0, CMD_IO_WRITE, 4'h0, '0, 4'h1, 1'b0, 3'h0);
        chk("no_claim", rsp_s, RSP_NOCLAIM);
        req(32'h0, CMD_IO_WRITE, 4'h0, 32'hdead_0000, 4'h1, 1'b1, 3'h2);
        wb(1'b0, OFS_DATA0, '0);
        chk("other_region", q, 32'h0000_0077);
        wb(1'b0, OFS_STATUS, '0);
        chk("claim_vector", q[15:8], 32'h0000_0004);
        chk("state_idle", q[3:0], 32'h0000_0001);
        wb(1'b0, 8'h40, '0);
        chk("unmapped", q, '0);
        // fifteen completed phases and thirty-two selected cycles over all scenarios
        chk("trdy_cycles", n_trdy, 32'h0000_000f);
        chk("devsel_cycles", n_sel, 32'h0000_0020);
        complete_run();
    end
endmodule
`default_nettype wire
